/* design/psq_pkg.sv */
package psq_pkg;

    // Mode field encodings.
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_MANUAL   = 2'h1;
    localparam logic [1:0] MODE_SEMI     = 2'h2;
    localparam logic [1:0] MODE_AUTO     = 2'h3;

    // Detection result codes reported in port status.
    localparam logic [2:0] DET_UNKNOWN   = 3'h0;
    localparam logic [2:0] DET_SHORT     = 3'h1;
    localparam logic [2:0] DET_LOW       = 3'h2;
    localparam logic [2:0] DET_GOOD      = 3'h3;
    localparam logic [2:0] DET_HIGH      = 3'h4;
    localparam logic [2:0] DET_OPEN      = 3'h5;

    // Signature resistance limits in ohms: must accept, must reject.
    localparam int unsigned RSIG_ACC_MIN_OHM = 19000;
    localparam int unsigned RSIG_ACC_MAX_OHM = 26500;
    localparam int unsigned RSIG_REJ_MAX_OHM = 33000;
    localparam int unsigned RSIG_REJ_MIN_OHM = 15000;

    // Thresholds in mA by class.
    localparam logic [9:0] ICUT_CLASS1_MA = 10'h070;
    localparam logic [9:0] ICUT_CLASS2_MA = 10'h0ce;
    localparam logic [9:0] ICUT_CLASS3_MA = 10'h177;
    localparam logic [9:0] ICUT_CLASS4_MA = 10'h27e;
    localparam logic [9:0] ILIM_TYPE1_MA  = 10'h1a9;
    localparam logic [9:0] ILIM_TYPE2_MA  = 10'h352;

    // Sense resistor setting: 0 means 0.5 ohm, 1 means 0.25 ohm.
    localparam logic SENSE_HALF_OHM    = 1'b0;
    localparam logic SENSE_QUARTER_OHM = 1'b1;

    // Backoff between detection passes.
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned BACKOFF_MS      = 100;
    localparam int unsigned BACKOFF_MID_MS  = 2000;
    localparam int unsigned BACKOFF_CYCLES     = BACKOFF_MS * 1000 * CLK_MHZ;
    localparam int unsigned BACKOFF_MID_CYCLES = BACKOFF_MID_MS * 1000 * CLK_MHZ;

    // Per-port host controls.
    typedef struct packed {
        logic [1:0] port_mode_field;
        logic       det_en;
        logic       cls_en;
        logic       dc_disc_en;
        logic       det_cmd;
        logic       cls_cmd;
        logic       pwr_on_cmd;
        logic       pwr_off_cmd;
    } psq_ctrl_t;

    // Per-port measurement results from the analog front end.
    typedef struct packed {
        logic        det_done;
        logic [16:0] rsig_ohm_div2;
        logic        cls_done;
        logic [2:0]  cls_result;
        logic        ilim_fault;
        logic        disconnect;
    } psq_meas_t;

    // Per-port status.
    typedef struct packed {
        logic [2:0] det_status;
        logic [2:0] cls_status;
        logic       power_on;
        logic       ac_disc_en;
        logic [9:0] icut_ma;
        logic [9:0] ilim_ma;
    } psq_stat_t;

endpackage : psq_pkg

/* design/psq_port.sv */
`timescale 1ns/10ps
`default_nettype none
module psq_port #(
    parameter int unsigned BACKOFF     = psq_pkg::BACKOFF_CYCLES,
    parameter int unsigned BACKOFF_MID = psq_pkg::BACKOFF_MID_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // Configuration
    input  wire logic               auto_latched,
    input  wire logic               auto_now,
    input  wire logic               mid_latched,
    input  wire psq_pkg::psq_ctrl_t ctrl,
    input  wire logic [9:0]         sw_icut_ma,
    input  wire logic [9:0]         sw_ilim_ma,
    // Front end
    input  wire psq_pkg::psq_meas_t meas,
    output logic                    det_start,
    output logic                    cls_start,
    output logic                    gate_on,
    // Status
    output psq_pkg::psq_stat_t      stat
);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DETECT  = 3'b001,
        ST_CLASS   = 3'b010,
        ST_BACKOFF = 3'b011,
        ST_POWERED = 3'b100
    } psq_pst_t;

    typedef struct packed {
        psq_pst_t   st;
        logic [31:0] cnt;
        logic        once;
        logic        det_start;
        logic        cls_start;
        logic        gate;
        logic [2:0]  det_status;
        logic [2:0]  cls_status;
        logic [9:0]  icut;
        logic [9:0]  ilim;
    } psq_port_state_t;

    psq_port_state_t s;
    psq_port_state_t next_s;

    logic       mode_auto;
    logic       det_good;
    logic [2:0] det_class;
    logic [9:0] class_icut;
    logic [9:0] class_ilim;
    logic       kill;

    // Doubling 17 bits gives the ohm value without overflow.
    function automatic logic [2:0] classify_r(input logic [17:0] r);
        logic [2:0] res;
        res = psq_pkg::DET_GOOD;
        if (r < 18'(psq_pkg::RSIG_ACC_MIN_OHM)) begin
            res = psq_pkg::DET_LOW;
        end else if (r > 18'(psq_pkg::RSIG_ACC_MAX_OHM)) begin
            res = psq_pkg::DET_HIGH;
        end
        return res;
    endfunction : classify_r

    always_comb begin
        // Automatic mode counts only while the strap was high at reset and still is.
        mode_auto = (ctrl.port_mode_field == psq_pkg::MODE_AUTO) && auto_latched && auto_now;
        det_class = classify_r({meas.rsig_ohm_div2, 1'b0});
        det_good  = (s.det_status == psq_pkg::DET_GOOD);
        case (s.cls_status)
            3'h1:    begin class_icut = psq_pkg::ICUT_CLASS1_MA; class_ilim = psq_pkg::ILIM_TYPE1_MA; end
            3'h2:    begin class_icut = psq_pkg::ICUT_CLASS2_MA; class_ilim = psq_pkg::ILIM_TYPE1_MA; end
            3'h4:    begin class_icut = psq_pkg::ICUT_CLASS4_MA; class_ilim = psq_pkg::ILIM_TYPE2_MA; end
            default: begin class_icut = psq_pkg::ICUT_CLASS3_MA; class_ilim = psq_pkg::ILIM_TYPE1_MA; end
        endcase
        kill = meas.ilim_fault || ctrl.pwr_off_cmd || (ctrl.dc_disc_en && meas.disconnect);
    end

    always_comb begin
        next_s           = s;
        next_s.det_start = 1'b0;
        next_s.cls_start = 1'b0;
        if (s.cnt != 32'h0) begin
            next_s.cnt = s.cnt - 32'h1;
        end
        // Thresholds follow the class only after an automatic-strap reset.
        if (auto_latched) begin
            next_s.icut = class_icut;
            next_s.ilim = class_ilim;
        end else begin
            next_s.icut = sw_icut_ma;
            next_s.ilim = sw_ilim_ma;
        end
        case (s.st)
            ST_IDLE: begin
                if (ctrl.port_mode_field == psq_pkg::MODE_MANUAL) begin
                    if (ctrl.det_cmd) begin
                        next_s.st        = ST_DETECT;
                        next_s.det_start = 1'b1;
                        next_s.once      = 1'b1;
                    end else if (ctrl.cls_cmd) begin
                        next_s.st        = ST_CLASS;
                        next_s.cls_start = 1'b1;
                        next_s.once      = 1'b1;
                    end
                end else if ((ctrl.port_mode_field == psq_pkg::MODE_SEMI || mode_auto) && ctrl.det_en) begin
                    next_s.st        = ST_DETECT;
                    next_s.det_start = 1'b1;
                    next_s.once      = 1'b0;
                end
                if (ctrl.port_mode_field != psq_pkg::MODE_SHUTDOWN && !mode_auto && ctrl.pwr_on_cmd && det_good
                    && !kill) begin
                    next_s.st   = ST_POWERED;
                    next_s.gate = 1'b1;
                end
            end
            ST_DETECT: begin
                if (meas.det_done) begin
                    next_s.det_status = det_class;
                    if (det_class == psq_pkg::DET_GOOD && (s.once ? 1'b0 : ctrl.cls_en)) begin
                        next_s.st        = ST_CLASS;
                        next_s.cls_start = 1'b1;
                    end else if (det_class == psq_pkg::DET_GOOD && mode_auto) begin
                        next_s.cls_status = 3'h3;
                        next_s.st         = ST_POWERED;
                        next_s.gate       = 1'b1;
                    end else begin
                        next_s.st  = s.once ? ST_IDLE : ST_BACKOFF;
                        next_s.cnt = mid_latched ? BACKOFF_MID : BACKOFF;
                    end
                end
            end
            ST_CLASS: begin
                if (meas.cls_done) begin
                    next_s.cls_status = meas.cls_result;
                    if (mode_auto && det_good) begin
                        next_s.st   = ST_POWERED;
                        next_s.gate = 1'b1;
                    end else begin
                        next_s.st  = s.once ? ST_IDLE : ST_BACKOFF;
                        next_s.cnt = mid_latched ? BACKOFF_MID : BACKOFF;
                    end
                end
            end
            ST_BACKOFF: begin
                if (s.cnt == 32'h0) begin
                    next_s.st = ST_IDLE;
                end else if (ctrl.pwr_on_cmd && det_good && !mode_auto && !kill) begin
                    next_s.st   = ST_POWERED;
                    next_s.gate = 1'b1;
                end
            end
            ST_POWERED: begin
                if (kill) begin
                    next_s.st         = ST_BACKOFF;
                    next_s.gate       = 1'b0;
                    next_s.det_status = psq_pkg::DET_UNKNOWN;
                    next_s.cnt        = mid_latched ? BACKOFF_MID : BACKOFF;
                end
            end
            default: next_s.st = ST_IDLE;
        endcase
        // Shutdown or reserved mode drops the gate and both start pulses on the next clock edge and returns to idle.
        if (ctrl.port_mode_field == psq_pkg::MODE_SHUTDOWN
            || (ctrl.port_mode_field == psq_pkg::MODE_AUTO && !mode_auto)) begin
            next_s.st        = ST_IDLE;
            next_s.gate      = 1'b0;
            next_s.det_start = 1'b0;
            next_s.cls_start = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s            <= '0;
            s.st         <= ST_IDLE;
            s.det_status <= psq_pkg::DET_UNKNOWN;
        end else begin
            s <= next_s;
        end
    end

    assign det_start       = s.det_start;
    assign cls_start       = s.cls_start;
    assign gate_on         = s.gate;
    assign stat.det_status = s.det_status;
    assign stat.cls_status = s.cls_status;
    assign stat.power_on   = s.gate;
    assign stat.ac_disc_en = ctrl.dc_disc_en;
    assign stat.icut_ma    = s.icut;
    assign stat.ilim_ma    = s.ilim;

    property p_no_power_shutdown;
        @(posedge clk) disable iff (reset)
        (ctrl.port_mode_field == psq_pkg::MODE_SHUTDOWN) |=> !gate_on;
    endproperty
    a_no_power_shutdown: assert property (p_no_power_shutdown) else $error("Port powered in shutdown.");

    property p_fault_kills;
        @(posedge clk) disable iff (reset)
        (gate_on && meas.ilim_fault) |=> !gate_on;
    endproperty
    a_fault_kills: assert property (p_fault_kills) else $error("Power kept after fault.");

    property p_disc_kills;
        @(posedge clk) disable iff (reset)
        (gate_on && ctrl.dc_disc_en && meas.disconnect) |=> !gate_on;
    endproperty
    a_disc_kills: assert property (p_disc_kills) else $error("Power kept after disconnect.");

    property p_off_cmd;
        @(posedge clk) disable iff (reset)
        (gate_on && ctrl.pwr_off_cmd) |=> !gate_on;
    endproperty
    a_off_cmd: assert property (p_off_cmd) else $error("Power-off command ignored.");

    property p_power_needs_detect;
        @(posedge clk) disable iff (reset)
        $rose(gate_on) |-> (stat.det_status == psq_pkg::DET_GOOD);
    endproperty
    a_power_needs_detect: assert property (p_power_needs_detect) else $error("Power without good detect.");

    property p_ac_mirror;
        @(posedge clk) disable iff (reset)
        stat.ac_disc_en == ctrl.dc_disc_en;
    endproperty
    a_ac_mirror: assert property (p_ac_mirror) else $error("AC enable does not mirror DC.");

    property p_class4_thresholds;
        @(posedge clk) disable iff (reset)
        (auto_latched && stat.cls_status == 3'h4) |=> (stat.icut_ma == psq_pkg::ICUT_CLASS4_MA
            && stat.ilim_ma == psq_pkg::ILIM_TYPE2_MA) || $changed(stat.cls_status);
    endproperty
    a_class4_thresholds: assert property (p_class4_thresholds) else $error("Class 4 thresholds wrong.");

    property p_sw_thresholds;
        @(posedge clk) disable iff (reset)
        !auto_latched ##1 !auto_latched |-> stat.icut_ma == $past(sw_icut_ma);
    endproperty
    a_sw_thresholds: assert property (p_sw_thresholds) else $error("Threshold not software held.");

    sequence s_semi_on;
        (ctrl.port_mode_field == psq_pkg::MODE_SEMI) && !gate_on && !ctrl.pwr_on_cmd;
    endsequence
    property p_semi_waits;
        @(posedge clk) disable iff (reset)
        s_semi_on |=> !gate_on;
    endproperty
    a_semi_waits: assert property (p_semi_waits) else $error("Semi-auto powered unasked.");

endmodule : psq_port
`default_nettype wire

/* design/psq_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module psq_sequencer #(
    parameter int unsigned PORTS       = 4,
    parameter int unsigned BACKOFF     = psq_pkg::BACKOFF_CYCLES,
    parameter int unsigned BACKOFF_MID = psq_pkg::BACKOFF_MID_CYCLES
) (
    // Clock and resets
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           reset_pin_n,
    input  wire logic                           reset_all,
    // Strap pins
    input  wire logic                           auto_strap,
    input  wire logic                           mid_strap,
    // Host controls
    input  wire logic                           cfg_wr,
    input  wire psq_pkg::psq_ctrl_t [PORTS-1:0] host_ctrl,
    input  wire logic                           sense_wr,
    input  wire logic                           sense_wdata,
    input  wire logic [9:0]                     sw_icut_ma,
    input  wire logic [9:0]                     sw_ilim_ma,
    // Front end
    input  wire psq_pkg::psq_meas_t [PORTS-1:0] meas,
    output logic [PORTS-1:0]                    det_start,
    output logic [PORTS-1:0]                    cls_start,
    output logic [PORTS-1:0]                    gate_on,
    // Status
    output psq_pkg::psq_stat_t [PORTS-1:0]      stat,
    output logic                                sense_quarter,
    output logic                                auto_latched,
    output logic                                mid_latched
);

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] auto_sync;
        logic [1:0] mid_sync;
        logic       rst_seen;
        logic       auto_l;
        logic       mid_l;
        logic       sense;
        logic [PORTS-1:0][3:0] cfg;
    } psq_top_state_t;

    psq_top_state_t s;
    psq_top_state_t next_s;
    logic           port_reset;

    // Reset pin and straps are asynchronous, so two flops each.
    always_comb begin
        next_s           = s;
        next_s.rst_sync  = {s.rst_sync[0], reset_pin_n};
        next_s.auto_sync = {s.auto_sync[0], auto_strap};
        next_s.mid_sync  = {s.mid_sync[0], mid_strap};
        next_s.rst_seen  = 1'b0;
        if (s.rst_seen) begin
            // Straps caught one cycle after any reset source releases.
            next_s.auto_l = s.auto_sync[1];
            next_s.mid_l  = s.mid_sync[1];
            next_s.sense  = s.auto_sync[1] ? psq_pkg::SENSE_QUARTER_OHM : psq_pkg::SENSE_HALF_OHM;
            for (int i = 0; i < PORTS; i++) begin
                next_s.cfg[i] = s.auto_sync[1] ? {psq_pkg::MODE_AUTO, 2'b11} : 4'h0;
            end
        end else begin
            if (sense_wr) begin
                next_s.sense = sense_wdata;
            end
            if (cfg_wr) begin
                for (int i = 0; i < PORTS; i++) begin
                    next_s.cfg[i] = {host_ctrl[i].port_mode_field, host_ctrl[i].det_en, host_ctrl[i].cls_en};
                end
            end
        end
    end

    assign port_reset = reset || reset_all || !s.rst_sync[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            // Straps keep shifting during reset, so the latch just after release sees the real pin level.
            s           <= '0;
            s.rst_sync  <= 2'b11;
            s.auto_sync <= next_s.auto_sync;
            s.mid_sync  <= next_s.mid_sync;
            s.rst_seen  <= 1'b1;
        end else if (reset_all || !s.rst_sync[1]) begin
            s          <= '0;
            s.rst_sync <= next_s.rst_sync;
            s.auto_sync <= next_s.auto_sync;
            s.mid_sync <= next_s.mid_sync;
            s.rst_seen <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sense_quarter = s.sense;
    assign auto_latched  = s.auto_l;
    assign mid_latched   = s.mid_l;

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        psq_pkg::psq_ctrl_t port_ctrl;
        always_comb begin
            port_ctrl                 = host_ctrl[p];
            port_ctrl.port_mode_field = s.cfg[p][3:2];
            port_ctrl.det_en          = s.cfg[p][1];
            port_ctrl.cls_en          = s.cfg[p][0];
        end
        psq_port #(
            .BACKOFF     (BACKOFF),
            .BACKOFF_MID (BACKOFF_MID)
        ) u_port (
            .clk          (clk),
            .reset        (port_reset),
            .auto_latched (s.auto_l),
            .auto_now     (s.auto_sync[1]),
            .mid_latched  (s.mid_l),
            .ctrl         (port_ctrl),
            .sw_icut_ma   (sw_icut_ma),
            .sw_ilim_ma   (sw_ilim_ma),
            .meas         (meas[p]),
            .det_start    (det_start[p]),
            .cls_start    (cls_start[p]),
            .gate_on      (gate_on[p]),
            .stat         (stat[p])
        );
    end

    property p_sense_default;
        @(posedge clk) disable iff (reset)
        $fell(s.rst_seen) && !sense_wr |=> sense_quarter == $past(s.auto_sync[1], 2);
    endproperty
    a_sense_default: assert property (p_sense_default) else $error("Sense default wrong.");

    property p_strap_hold;
        @(posedge clk) disable iff (reset || reset_all || !s.rst_sync[1])
        !s.rst_seen ##1 !s.rst_seen |-> $stable(auto_latched);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("Strap relatched without reset.");

endmodule : psq_sequencer
`default_nettype wire

/* bench/psq_pd_model.sv */
`timescale 1ns/10ps
`default_nettype none
module psq_pd_model #(
    parameter int unsigned PORTS = 4
) (
    // Clock
    input  wire logic                      clk,
    // Sequencer requests
    input  wire logic [PORTS-1:0]          det_start,
    input  wire logic [PORTS-1:0]          cls_start,
    // Scenario controls
    input  wire logic [16:0]               rsig_half,
    input  wire logic [2:0]                cls_code,
    input  wire logic [3:0]                lag,
    input  wire logic [PORTS-1:0]          fault,
    input  wire logic [PORTS-1:0]          unplug,
    // Measurements
    output var  psq_pkg::psq_meas_t [PORTS-1:0] meas
);
    int dcnt [PORTS];
    int ccnt [PORTS];
    initial meas = '0;
    always @(posedge clk) begin
        for (int p = 0; p < PORTS; p++) begin
            dcnt[p] <= det_start[p] ? lag + 1 : (dcnt[p] > 0 ? dcnt[p] - 1 : 0);
            ccnt[p] <= cls_start[p] ? lag + 1 : (ccnt[p] > 0 ? ccnt[p] - 1 : 0);
            // Result lines toggle outside the done pulse so a stale value is never mistaken for a result.
            meas[p].det_done      <= (dcnt[p] == 1);
            meas[p].rsig_ohm_div2 <= (dcnt[p] == 1) ? rsig_half : ~meas[p].rsig_ohm_div2;
            meas[p].cls_done      <= (ccnt[p] == 1);
            meas[p].cls_result    <= (ccnt[p] == 1) ? cls_code : ~meas[p].cls_result;
            meas[p].ilim_fault    <= fault[p];
            meas[p].disconnect    <= unplug[p];
        end
    end
endmodule : psq_pd_model
`default_nettype wire

/* bench/psq_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module psq_sequencer_tb;
    logic                           clk = 1'b0, reset = 1'b1, reset_pin_n = 1'b1, reset_all = 1'b0;
    logic                           auto_strap = 1'b0, mid_strap = 1'b0, cfg_wr = 1'b0;
    logic                           sense_wr = 1'b0, sense_wdata = 1'b0;
    psq_pkg::psq_ctrl_t [3:0]       hc = '0;
    logic [16:0]                    rsig_half = 17'h030d4;
    logic [2:0]                     cls_code = 3'h3;
    logic [9:0]                     sw_icut = 10'h0aa, sw_ilim = 10'h155;
    logic [3:0]                     fault = '0, unplug = '0;
    psq_pkg::psq_meas_t [3:0]       meas;
    logic [3:0]                     det_start, cls_start, gate_on;
    psq_pkg::psq_stat_t [3:0]       stat;
    logic                           sense_quarter, auto_latched, mid_latched;
    logic                           watch_off = 1'b0, seen_off = 1'b0;
    int                             err_total = 0, checks = 0;
    logic [9:0]                     icut_tab [5] = '{psq_pkg::ICUT_CLASS3_MA, psq_pkg::ICUT_CLASS1_MA,
        psq_pkg::ICUT_CLASS2_MA, psq_pkg::ICUT_CLASS3_MA, psq_pkg::ICUT_CLASS4_MA};
    logic [16:0]                    rs_tab [4] = '{17'h04074, 17'h01ce8, 17'h033c2, 17'h0251c};
    logic [2:0]                     ds_tab [4] = '{psq_pkg::DET_HIGH, psq_pkg::DET_LOW, 3'h3, 3'h3};

    always #5 clk = ~clk;

    psq_sequencer #(.PORTS(4), .BACKOFF(20), .BACKOFF_MID(40)) i_dut (.clk(clk), .reset(reset),
        .reset_pin_n(reset_pin_n), .reset_all(reset_all), .auto_strap(auto_strap), .mid_strap(mid_strap),
        .cfg_wr(cfg_wr), .host_ctrl(hc), .sense_wr(sense_wr), .sense_wdata(sense_wdata),
        .sw_icut_ma(sw_icut), .sw_ilim_ma(sw_ilim), .meas(meas), .det_start(det_start),
        .cls_start(cls_start), .gate_on(gate_on), .stat(stat), .sense_quarter(sense_quarter),
        .auto_latched(auto_latched), .mid_latched(mid_latched));
    psq_pd_model #(.PORTS(4)) i_pd (.clk(clk), .det_start(det_start), .cls_start(cls_start),
        .rsig_half(rsig_half), .cls_code(cls_code), .lag(4'h2), .fault(fault), .unplug(unplug), .meas(meas));

    // Ports 2 and 3 sit in shutdown and reserved mode while this watch is on.
    always @(posedge clk) if (watch_off && |{det_start[3:2], cls_start[3:2], gate_on[3:2]}) seen_off <= 1'b1;

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_on(input int p, input bit det, input logic [2:0] val);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (det ? stat[p].det_status === val : gate_on[p] === val[0]) break;
        end
        checks++;
        if (n == 400) begin
            err_total++;
            $display("wrong value at %0t: wait on port %0d ran out", $time, p);
            wrap_up();
        end
    endtask : wait_on
    task automatic gap(input int p, input int min);
        int n;
        for (n = 0; n < 500 && det_start[p] !== 1'b1; n++) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (det_start[p] !== 1'b1 && n < 500);
        chk(n >= min && n < 500, 1'b1);
    endtask : gap
    task automatic pulse(input int p, input logic [2:0] k);
        @(posedge clk);
        {hc[p].pwr_off_cmd, hc[p].pwr_on_cmd, hc[p].det_cmd} <= k;
        @(posedge clk);
        {hc[p].pwr_off_cmd, hc[p].pwr_on_cmd, hc[p].det_cmd} <= 3'h0;
    endtask : pulse
    task automatic cfg(input int p, input logic [1:0] mode, input logic det, input logic cls, input logic dc);
        @(posedge clk);
        hc[p].port_mode_field <= mode;
        hc[p].det_en <= det;
        hc[p].cls_en <= cls;
        hc[p].dc_disc_en <= dc;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask : cfg
    task automatic do_reset(input logic a, input logic m);
        @(posedge clk);
        auto_strap <= a;
        mid_strap <= m;
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset

    initial begin
        do_reset(1'b0, 1'b0);
        chk({auto_latched, mid_latched, sense_quarter}, 3'h0);
        watch_off <= 1'b1;
        @(posedge clk);
        sense_wr <= 1'b1;
        sense_wdata <= 1'b1;
        @(posedge clk);
        sense_wr <= 1'b0;
        @(posedge clk);
        chk(sense_quarter, 1'b1);
        cfg(1, 2'h1, 1'b0, 1'b0, 1'b0);
        cfg(3, 2'h3, 1'b1, 1'b1, 1'b0);
        cfg(0, 2'h2, 1'b1, 1'b0, 1'b1);
        wait_on(0, 1'b1, psq_pkg::DET_GOOD);
        chk(gate_on[0], 1'b0);
        gap(0, 20);
        chk({stat[1].ac_disc_en, stat[0].ac_disc_en}, 2'h1);
        chk(stat[1].det_status, psq_pkg::DET_UNKNOWN);
        pulse(1, 3'h1);
        wait_on(1, 1'b1, psq_pkg::DET_GOOD);
        pulse(2, 3'h2);
        sw_icut <= 10'h0bb;
        pulse(1, 3'h2);
        wait_on(1, 1'b0, 3'h1);
        chk({stat[1].icut_ma, stat[1].ilim_ma}, {10'h0bb, 10'h155});
        unplug[1] <= 1'b1;
        repeat (5) @(posedge clk);
        chk(gate_on[1], 1'b1);
        fault[1] <= 1'b1;
        wait_on(1, 1'b0, 3'h0);
        {fault[1], unplug[1]} <= 2'h0;
        for (int i = 0; i < 4; i++) begin
            rsig_half <= rs_tab[i];
            wait_on(0, 1'b1, ds_tab[i]);
            pulse(0, 3'h2);
            repeat (3) @(posedge clk);
            chk(gate_on[0], ds_tab[i] == psq_pkg::DET_GOOD);
            if (i == 2) pulse(0, 3'h4);
            if (i == 2) wait_on(0, 1'b0, 3'h0);
        end
        unplug[0] <= 1'b1;
        wait_on(0, 1'b0, 3'h0);
        unplug[0] <= 1'b0;
        wait_on(0, 1'b1, psq_pkg::DET_GOOD);
        pulse(0, 3'h2);
        wait_on(0, 1'b0, 3'h1);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk({gate_on[0], sense_quarter}, 2'h0);
        reset_pin_n <= 1'b1;
        chk(seen_off, 1'b0);
        watch_off <= 1'b0;
        rsig_half <= 17'h07530;
        hc <= '0;
        do_reset(1'b1, 1'b1);
        chk({auto_latched, mid_latched, sense_quarter}, 3'h7);
        for (int p = 0; p < 4; p++) hc[p].dc_disc_en <= 1'b1;
        gap(0, 40);
        for (int c = 0; c < 5; c++) begin
            cls_code <= 3'(c);
            rsig_half <= 17'h030d4;
            wait_on(0, 1'b0, 3'h1);
            // Thresholds follow the class register one cycle after power comes on.
            @(posedge clk);
            chk({stat[0].icut_ma, stat[0].ilim_ma}, {icut_tab[c], c == 4 ? 10'h352 : 10'h1a9});
            unplug[0] <= 1'b1;
            wait_on(0, 1'b0, 3'h0);
            unplug[0] <= 1'b0;
        end
        cls_code <= 3'h1;
        for (int p = 1; p < 4; p++) cfg(p, 2'h3, 1'b1, 1'b1, 1'b1);
        cfg(0, 2'h3, 1'b1, 1'b0, 1'b1);
        wait_on(0, 1'b0, 3'h1);
        @(posedge clk);
        chk({stat[0].icut_ma, stat[0].ilim_ma}, {psq_pkg::ICUT_CLASS3_MA, psq_pkg::ILIM_TYPE1_MA});
        auto_strap <= 1'b0;
        wait_on(0, 1'b0, 3'h0);
        chk(auto_latched, 1'b1);
        reset_all <= 1'b1;
        @(posedge clk);
        reset_all <= 1'b0;
        repeat (5) @(posedge clk);
        chk({auto_latched, gate_on}, 5'h0);
        wrap_up();
    end
endmodule : psq_sequencer_tb
`default_nettype wire
